/* File: i2cms_pkg.sv */
// Constants and types shared by the two-wire bus controller
package i2cms_pkg;

  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STAT    = 8'h04;
  localparam logic [7:0]  OFF_DATA    = 8'h08;
  localparam logic [7:0]  OFF_SADDR   = 8'h0c;
  localparam logic [7:0]  OFF_CFG     = 8'h10;

  localparam int          CTRL_EN_POS   = 7;
  localparam int          CTRL_IE_POS   = 6;
  localparam int          CTRL_MST_POS  = 5;
  localparam int          CTRL_TX_POS   = 4;
  localparam int          CTRL_ACK_SUPPRESS_POS = 3;
  localparam int          CTRL_REPEAT_START_CMD_POS = 2;
  localparam int          STAT_DONE_POS = 7;
  localparam int          STAT_HIT_POS  = 6;
  localparam int          STAT_BUSY_POS = 5;
  localparam int          STAT_ARB_POS  = 4;
  localparam int          STAT_SDIR_POS = 2;
  localparam int          STAT_IFL_POS  = 1;
  localparam int          STAT_ACKN_POS = 0;
  localparam int          CFG_GCEN_POS  = 7;

  localparam int          CLK_NS      = 10;
  localparam int          QTR_NS      = 2500;
  localparam int          QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  QTR_LAST    = 8'(QTR_CYC - 1);
  localparam logic [6:0]  SADDR_RST   = 7'h00;
  localparam logic [6:0]  GCALL_ADDR  = 7'h00;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;

  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_MSTART = 10'h002,
    ST_MHOLD  = 10'h004,
    ST_MBIT   = 10'h008,
    ST_MSTOP  = 10'h010,
    ST_MRSTA  = 10'h020,
    ST_SRX    = 10'h040,
    ST_SACK   = 10'h080,
    ST_SHOLD  = 10'h100,
    ST_STX    = 10'h200
  } i2cms_fsm_t;

  typedef struct packed {
    logic       en;
    logic       ie;
    logic       master_select;
    logic       tx;
    logic       ack_suppress;
    logic       repeat_start_cmd;
    logic [1:0] rsv;
  } i2cms_ctrl_t;

  typedef struct packed {
    logic done;
    logic hit;
    logic busy;
    logic arb_lost_flag;
    logic rsv;
    logic sdir;
    logic ifl;
    logic ack_n;
  } i2cms_stat_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cms_pins_t;

  typedef struct packed {
    i2cms_ctrl_t ctrl;
    i2cms_stat_t stat;
    logic [6:0]  saddr;
    logic        gcen;
    i2cms_fsm_t  st;
    logic [1:0]  ph;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [7:0]  rxd;
    logic        first;
    logic [7:0]  qcnt;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    i2cms_pins_t pins;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } i2cms_state_t;

  localparam i2cms_ctrl_t  CTRL_RST = 8'h00;
  localparam i2cms_stat_t  STAT_RST = 8'h80;
  localparam i2cms_pins_t  PINS_RST = 4'h0;

  localparam i2cms_state_t STATE_RST = '{
    ctrl: CTRL_RST, stat: STAT_RST, saddr: SADDR_RST, gcen: 1'b0, st: ST_IDLE,
    ph: 2'h0, cnt: 4'h0, shift: 8'h00, rxd: 8'h00, first: 1'b0, qcnt: 8'h00,
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
    sda_s3: 1'b1, pins: PINS_RST, irq: 1'b0, prdata: 32'h0000_0000,
    pready: 1'b0, pslverr: 1'b0};

endpackage

/* File: i2cms_ctrl.sv */
// Two-wire bus master/slave controller with APB register access
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module i2cms_ctrl (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [i2cms_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [i2cms_pkg::DATA_W-1:0]  pwdata,
  output wire logic [i2cms_pkg::DATA_W-1:0]  prdata,
  output wire logic                          pready,
  output wire logic                          pslverr,
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output wire i2cms_pkg::i2cms_pins_t        pins,
  output wire logic                          irq
);
  import i2cms_pkg::*;

  i2cms_state_t s;
  i2cms_state_t n;
  logic         tick;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         acc;
  logic         wr;
  logic         rd;
  logic         mstate;

  // Marks a lost arbitration and drops off the bus without a stop
  function automatic i2cms_state_t lose_arb(input i2cms_state_t x);
    x.stat.arb_lost_flag    = 1'b1;
    x.stat.ifl     = 1'b1;
    x.ctrl.master_select     = 1'b0;
    x.pins.scl_oe  = 1'b0;
    x.pins.sda_oe  = 1'b0;
    x.st           = ST_IDLE;
    return x;
  endfunction

  assign tick      = (s.qcnt == QTR_LAST);
  assign scl_rise  = s.scl_s2 & ~s.scl_s3;
  assign scl_fall  = ~s.scl_s2 & s.scl_s3;
  assign start_det = s.scl_s2 & s.scl_s3 & s.sda_s3 & ~s.sda_s2;
  assign stop_det  = s.scl_s2 & s.scl_s3 & ~s.sda_s3 & s.sda_s2;
  assign acc       = psel & penable & s.pready;
  assign wr        = acc & pwrite;
  assign rd        = acc & ~pwrite;
  assign mstate    = s.st inside {ST_MSTART, ST_MHOLD, ST_MBIT, ST_MSTOP, ST_MRSTA};

  always_comb begin
    n = s;
    n.scl_s1 = scl_i;
    n.scl_s2 = s.scl_s1;
    n.scl_s3 = s.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = s.sda_s1;
    n.sda_s3 = s.sda_s2;
    n.qcnt   = tick ? 8'h00 : s.qcnt + 8'h01;

    // Bus monitor
    if (start_det) begin
      n.stat.busy = 1'b1;
    end else if (stop_det) begin
      n.stat.busy = 1'b0;
    end

    // APB answer: one wait state, data and error prepared with pready
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        OFF_CTRL:  n.prdata[7:0] = {s.ctrl[7:3], 3'h0};
        OFF_STAT:  n.prdata[7:0] = s.stat;
        OFF_DATA:  n.prdata[7:0] = s.rxd;
        OFF_SADDR: n.prdata[7:0] = {s.saddr, 1'b0};
        OFF_CFG:   n.prdata[CFG_GCEN_POS] = s.gcen;
        default:   n.pslverr = 1'b1;
      endcase
    end

    // Register writes and data-port side effects
    if (wr && paddr == OFF_CTRL) begin
      n.stat.hit     = 1'b0;
      n.ctrl         = i2cms_ctrl_t'(pwdata[7:0]);
      n.ctrl.repeat_start_cmd    = 1'b0;
      n.ctrl.rsv     = 2'h0;
      if (pwdata[CTRL_MST_POS] && !s.ctrl.master_select) begin
        if (s.st == ST_IDLE && !s.stat.busy && pwdata[CTRL_EN_POS]) begin
          n.st    = ST_MSTART;
          n.ph    = 2'h0;
          n.first = 1'b1;
        end else begin
          n = lose_arb(n);
        end
      end
      if (pwdata[CTRL_REPEAT_START_CMD_POS] && s.ctrl.master_select && pwdata[CTRL_MST_POS]) begin
        if (s.st == ST_MHOLD) begin
          n.st = ST_MRSTA;
          n.ph = 2'h0;
        end else begin
          n = lose_arb(n);
        end
      end
    end
    if (wr && paddr == OFF_STAT) begin
      if (pwdata[STAT_ARB_POS]) begin
        n.stat.arb_lost_flag = 1'b0;
      end
      if (pwdata[STAT_IFL_POS]) begin
        n.stat.ifl = 1'b0;
      end
    end
    if (wr && paddr == OFF_SADDR) begin
      n.saddr = pwdata[7:1];
    end
    if (wr && paddr == OFF_CFG) begin
      n.gcen = pwdata[CFG_GCEN_POS];
    end
    if (wr && paddr == OFF_DATA && s.ctrl.tx) begin
      n.stat.done = 1'b0;
      n.shift     = pwdata[7:0];
      if (s.st == ST_MHOLD) begin
        n.st  = ST_MBIT;
        n.ph  = 2'h0;
        n.cnt = 4'h0;
      end else if (s.st == ST_SHOLD) begin
        n.st          = ST_STX;
        n.cnt         = 4'h0;
        n.pins.sda_oe = ~pwdata[7];
        n.pins.scl_oe = 1'b0;
      end
    end
    if (rd && paddr == OFF_DATA && !s.ctrl.tx) begin
      n.stat.done = 1'b0;
      if (s.st == ST_MHOLD) begin
        n.st  = ST_MBIT;
        n.ph  = 2'h0;
        n.cnt = 4'h0;
      end else if (s.st == ST_SHOLD) begin
        n.st          = ST_SRX;
        n.first       = 1'b0;
        n.cnt         = 4'h0;
        n.pins.scl_oe = 1'b0;
      end
    end

    // Bus engine
    case (s.st)
      ST_IDLE: begin
      end
      ST_MSTART: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              n.pins.sda_oe = 1'b1;
              n.ph          = 2'h1;
            end
            2'h1: n.ph = 2'h2;
            default: begin
              n.pins.scl_oe = 1'b1;
              n.st          = ST_MHOLD;
            end
          endcase
        end
      end
      ST_MHOLD: begin
        if (!s.ctrl.master_select) begin
          n.st = ST_MSTOP;
          n.ph = 2'h0;
        end
      end
      ST_MBIT: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              if (s.cnt == BITS_BYTE) begin
                n.pins.sda_oe = s.ctrl.tx ? 1'b0 : ~s.ctrl.ack_suppress;
              end else begin
                n.pins.sda_oe = s.ctrl.tx ? ~s.shift[7] : 1'b0;
              end
              n.ph = 2'h1;
            end
            2'h1: begin
              n.pins.scl_oe = 1'b0;
              n.ph          = 2'h2;
            end
            2'h2: begin
              if (s.scl_s2) begin
                n.ph = 2'h3;
                if (s.cnt == BITS_BYTE) begin
                  if (s.ctrl.tx) begin
                    n.stat.ack_n = s.sda_s2;
                  end
                end else begin
                  n.shift = {s.shift[6:0], s.sda_s2};
                  if (s.ctrl.tx && s.shift[7] && !s.sda_s2) begin
                    n = lose_arb(n);
                    if (s.first) begin
                      n.st  = ST_SRX;
                      n.cnt = s.cnt + 4'h1;
                    end
                  end
                end
              end
            end
            default: begin
              n.pins.scl_oe = 1'b1;
              n.ph          = 2'h0;
              if (s.cnt == BITS_BYTE) begin
                n.stat.done   = 1'b1;
                n.stat.ifl    = 1'b1;
                n.pins.sda_oe = 1'b0;
                n.first       = 1'b0;
                n.st          = ST_MHOLD;
                if (!s.ctrl.tx) begin
                  n.rxd = s.shift;
                end
              end else begin
                n.cnt = s.cnt + 4'h1;
              end
            end
          endcase
        end
      end
      ST_MSTOP: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              n.pins.sda_oe = 1'b1;
              n.ph          = 2'h1;
            end
            2'h1: begin
              n.pins.scl_oe = 1'b0;
              n.ph          = 2'h2;
            end
            default: begin
              if (s.scl_s2) begin
                n.pins.sda_oe = 1'b0;
                n.st          = ST_IDLE;
              end
            end
          endcase
        end
      end
      ST_MRSTA: begin
        if (tick) begin
          case (s.ph)
            2'h0: begin
              n.pins.sda_oe = 1'b0;
              n.ph          = 2'h1;
            end
            2'h1: begin
              n.pins.scl_oe = 1'b0;
              n.ph          = 2'h2;
            end
            2'h2: begin
              if (s.scl_s2) begin
                n.pins.sda_oe = 1'b1;
                n.ph          = 2'h3;
              end
            end
            default: begin
              n.pins.scl_oe = 1'b1;
              n.first       = 1'b1;
              n.st          = ST_MHOLD;
            end
          endcase
        end
      end
      ST_SRX: begin
        if (scl_rise && s.cnt != BITS_BYTE) begin
          n.shift = {s.shift[6:0], s.sda_s2};
          n.cnt   = s.cnt + 4'h1;
        end else if (scl_fall && s.cnt == BITS_BYTE) begin
          if (s.first) begin
            if (s.shift[7:1] == s.saddr || (s.gcen && s.shift[7:1] == GCALL_ADDR)) begin
              n.stat.hit    = 1'b1;
              n.stat.sdir   = s.shift[0];
              n.rxd         = s.shift;
              n.stat.ifl    = 1'b1;
              n.stat.done   = 1'b1;
              n.pins.sda_oe = 1'b1;
              n.st          = ST_SACK;
            end else begin
              n.st = ST_IDLE;
            end
          end else begin
            n.rxd         = s.shift;
            n.stat.done   = 1'b1;
            n.stat.ifl    = 1'b1;
            n.pins.sda_oe = ~s.ctrl.ack_suppress;
            n.st          = ST_SACK;
          end
        end
      end
      ST_SACK: begin
        if (scl_fall) begin
          n.pins.sda_oe = 1'b0;
          n.pins.scl_oe = 1'b1;
          n.cnt         = 4'h0;
          n.st          = ST_SHOLD;
        end
      end
      ST_SHOLD: begin
      end
      ST_STX: begin
        if (scl_rise && s.cnt == BITS_BYTE) begin
          n.stat.ack_n = s.sda_s2;
          n.stat.done  = 1'b1;
          n.stat.ifl   = 1'b1;
        end else if (scl_fall) begin
          if (s.cnt == BITS_BYTE) begin
            n.pins.scl_oe = ~s.stat.ack_n;
            n.st          = s.stat.ack_n ? ST_IDLE : ST_SHOLD;
          end else begin
            n.cnt         = s.cnt + 4'h1;
            n.shift       = {s.shift[6:0], 1'b0};
            n.pins.sda_oe = (s.cnt < 4'h7) ? ~s.shift[6] : 1'b0;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // Slave side follows starts and stops made by other masters
    if (!mstate && start_det) begin
      n.st          = ST_SRX;
      n.first       = 1'b1;
      n.cnt         = 4'h0;
      n.pins.scl_oe = 1'b0;
      n.pins.sda_oe = 1'b0;
    end else if (!mstate && stop_det) begin
      n.st          = ST_IDLE;
      n.pins.scl_oe = 1'b0;
      n.pins.sda_oe = 1'b0;
    end

    if (!n.ctrl.en) begin
      n.st          = ST_IDLE;
      n.ctrl.master_select    = 1'b0;
      n.pins.scl_oe = 1'b0;
      n.pins.sda_oe = 1'b0;
    end
    n.pins.scl_o = 1'b0;
    n.pins.sda_o = 1'b0;
    n.irq        = n.ctrl.ie & n.stat.ifl;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign pins    = s.pins;
  assign irq     = s.irq;

endmodule

/* File: i2cms_ctrl_asserts.sv */
// Port-level property checker for the two-wire bus controller
`timescale 1ns/10ps
module i2cms_ctrl_asserts (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [i2cms_pkg::ADDR_W-1:0] paddr,
  input wire logic [i2cms_pkg::DATA_W-1:0] pwdata,
  input wire logic [i2cms_pkg::DATA_W-1:0] prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         scl_i,
  input wire logic                         sda_i,
  input wire i2cms_pkg::i2cms_pins_t       pins,
  input wire logic                         irq
);
  import i2cms_pkg::*;
  logic        en_q;
  logic        ie_q;
  logic        mst_q;
  logic [1:0]  dir_q;
  logic [1:0]  off_q;
  logic        busy_q;
  logic [3:0]  quiet_q;
  logic [10:0] stop_q;
  logic        scl_q;
  logic        sda_q;
  wire         acc     = psel && penable && pready;
  wire         wr_ctrl = acc && pwrite && paddr == OFF_CTRL;
  wire         rd_ctrl = acc && !pwrite && paddr == OFF_CTRL;
  wire         rd_stat = acc && !pwrite && paddr == OFF_STAT;
  wire         edge_hi = scl_i && scl_q && sda_i != sda_q;

  // Mirrors control writes and the start and stop edges seen on the wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q    <= 1'b0;
      ie_q    <= 1'b0;
      mst_q   <= 1'b0;
      dir_q   <= 2'h0;
      off_q   <= 2'h0;
      busy_q  <= 1'b0;
      quiet_q <= 4'h0;
      stop_q  <= 11'h000;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (wr_ctrl) begin
        en_q  <= pwdata[CTRL_EN_POS];
        ie_q  <= pwdata[CTRL_IE_POS];
        dir_q <= pwdata[4:3];
        mst_q <= pwdata[CTRL_MST_POS] && pwdata[CTRL_EN_POS] && (mst_q || (scl_i && sda_i));
      end
      off_q <= en_q ? 2'h0 : (off_q == 2'h3 ? 2'h3 : off_q + 2'h1);
      if (edge_hi) begin
        busy_q  <= sda_q;
        quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
        quiet_q <= quiet_q + 4'h1;
      end
      if (wr_ctrl && mst_q && !pwdata[CTRL_MST_POS]) begin
        stop_q <= 11'h001;
      end else if (edge_hi && sda_i) begin
        stop_q <= 11'h000;
      end else if (stop_q != 11'h000) begin
        stop_q <= stop_q + 11'h001;
      end
    end
  end

  a_idle_when_off: assert property (@(posedge pclk) disable iff (!presetn)
    off_q == 2'h3 |-> !pins.scl_oe && !pins.sda_oe) else $error("pins pulled while disabled");
  a_irq_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !pwdata[CTRL_IE_POS] |-> ##2 !irq [*3]) else $error("irq with enable off");
  a_start_on_select: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && pwdata[CTRL_MST_POS] && pwdata[CTRL_EN_POS] && !mst_q && scl_i && sda_i
    |-> ##[1:600] (edge_hi && !sda_i)) else $error("no start after master select");
  a_stop_on_release: assert property (@(posedge pclk) disable iff (!presetn)
    stop_q != 11'h000 |-> stop_q < 11'h5dc) else $error("no stop after master release");
  a_ctrl_bits_hold: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ctrl |-> prdata[CTRL_EN_POS] == en_q && prdata[CTRL_IE_POS] == ie_q
    && prdata[4:3] == dir_q) else $error("control readback differs");
  a_repeat_start_cmd_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ctrl |-> prdata[CTRL_REPEAT_START_CMD_POS] == 1'b0 && prdata[1:0] == 2'h0) else $error("repeat bit read 1");
  a_hit_after_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl ##[1:3] (psel && !penable && !pwrite && paddr == OFF_STAT)
    |-> ##2 (pready && !prdata[STAT_HIT_POS])) else $error("hit flag survived control write");
  a_busy_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    rd_stat && en_q && quiet_q == 4'hf |-> prdata[STAT_BUSY_POS] == busy_q)
    else $error("busy flag differs from wire");
endmodule

bind i2cms_ctrl i2cms_ctrl_asserts i2cms_ctrl_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .sda_i(sda_i), .pins(pins), .irq(irq));

/* File: i2cms_peer.sv */
// Far-side model: a master and a responding slave on the two-wire bus
`timescale 1ns/10ps
module i2cms_peer (
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  ack_on,
  input  wire logic  talk,
  input  wire logic [7:0] tx_val,
  output logic       scl_pull,
  output logic       sda_pull,
  output logic [7:0] rx_byte
);
  int   bits;
  logic mastering;

  initial begin
    scl_pull  = 1'b0;
    sda_pull  = 1'b0;
    rx_byte   = 8'h00;
    bits      = 10;
    mastering = 1'b0;
  end

  // Start restarts the bit count, stop ends it
  always @(sda) if (scl === 1'b1 && !mastering) bits = sda ? 10 : 0;

  always @(posedge scl) begin
    if (!mastering && bits < 8) begin
      rx_byte = {rx_byte[6:0], sda};
      bits++;
    end
  end

  // Responder sends tx_val msb first while talk is high, first bit as talk rises
  always @(talk) sda_pull = talk & ~tx_val[7];

  // Acknowledge slot of the responder and its data bits when talking
  always @(negedge scl) begin
    if (!mastering && bits == 8) begin
      sda_pull = ack_on;
      bits = 9;
    end else if (!mastering && bits == 9) begin
      sda_pull = talk & ~tx_val[7];
      bits = 0;
    end else if (!mastering && talk && bits < 8) begin
      sda_pull = ~tx_val[7 - bits];
    end
  end

  // Start, then nine clocks at 80 ns; waits while the other side stretches
  task send(input logic [7:0] val, output logic ack_n);
    mastering = 1'b1;
    sda_pull = 1'b1;
    #160;
    for (int i = 0; i < 9; i++) begin
      scl_pull = 1'b1;
      #20;
      sda_pull = (i < 8) ? ~val[7 - i] : 1'b0;
      #20;
      scl_pull = 1'b0;
      wait (scl === 1'b1);
      #40;
      ack_n = sda;
    end
    scl_pull = 1'b1;
  endtask

  task stop;
    sda_pull = 1'b1;
    #40;
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    #40;
    sda_pull = 1'b0;
    #40;
    mastering = 1'b0;
  endtask
endmodule

/* File: i2cms_ctrl_bench.sv */
// Self-checking bench for the two-wire bus controller
`timescale 1ns/10ps
module i2cms_ctrl_bench;
  import i2cms_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  i2cms_pins_t pins;
  logic        irq;
  logic        scl_pull;
  logic        sda_pull;
  logic        ack_on;
  logic [7:0]  rx_byte;
  logic        talk;
  logic [7:0]  tx_val;
  wire         scl = ~(pins.scl_oe | scl_pull);
  wire         sda = ~(pins.sda_oe | sda_pull);
  int          err_count;
  int          tests_run;
  int          seed;
  logic [31:0] r;
  logic        e;
  logic        an;
  logic [6:0]  own;
  logic [6:0]  ad;
  logic [7:0]  b;

  i2cms_ctrl i2cms_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .pins(pins), .irq(irq));
  i2cms_peer i2cms_peer_inst (.scl(scl), .sda(sda), .ack_on(ack_on), .talk(talk),
    .tx_val(tx_val), .scl_pull(scl_pull), .sda_pull(sda_pull), .rx_byte(rx_byte));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task wait_done;
    do begin
      repeat (200) @(posedge pclk);
      rd(OFF_STAT);
    end while (r[STAT_DONE_POS] !== 1'b1);
  endtask

  task tally_and_finish;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #900000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    seed = 32'h9a72d199;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack_on = 1'b0;
    talk = 1'b0;
    tx_val = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL);
    chk(r, 32'h00);
    rd(OFF_STAT);
    chk(r, 32'h80);
    wr(OFF_CTRL, 8'h04);
    rd(OFF_CTRL);
    chk(r, 32'h00);
    rd(8'h14);
    chk(e, 1'b1);
    chk(r, 32'h00);
    own = 7'h10 + 7'($random(seed) & 32'h3f);
    wr(OFF_SADDR, {own, 1'b0});
    // Disabled, enabled with a foreign address, addressed, then general call
    for (int t = 0; t < 4; t++) begin
      ad = (t == 1) ? own ^ 7'h01 : (t == 3) ? GCALL_ADDR : own;
      if (t == 3) begin
        wr(OFF_CFG, 8'h80);
      end
      wr(OFF_CTRL, (t == 0) ? 8'h00 : 8'h80);
      i2cms_peer_inst.send({ad, 1'b0}, an);
      chk(an, (t >= 2) ? 0 : 1);
      rd(OFF_STAT);
      chk(r[STAT_HIT_POS], t >= 2);
      if (t == 3) begin
        rd(OFF_DATA);
        chk(r, {24'h0, ad, 1'b0});
      end
      if (t == 2) begin
        chk(r, 32'he2);
        wr(OFF_CTRL, 8'he0);
        rd(OFF_STAT);
        chk(r[STAT_HIT_POS], 1'b0);
        repeat (300) @(posedge pclk);
        rd(OFF_STAT);
        chk(r, 32'hb2);
        chk(irq, 1'b1);
        rd(OFF_CTRL);
        chk(r, 32'hc0);
        wr(OFF_STAT, 8'h12);
        rd(OFF_STAT);
        chk(r, 32'ha0);
        chk(irq, 1'b0);
        rd(OFF_DATA);
        chk(r, {24'h0, ad, 1'b0});
        rd(OFF_STAT);
        chk(r[STAT_DONE_POS], 1'b0);
      end
      i2cms_peer_inst.stop();
      repeat (20) @(posedge pclk);
      rd(OFF_STAT);
      chk(r[STAT_BUSY_POS], 1'b0);
    end
    ad = 7'($random(seed));
    wr(OFF_CTRL, 8'hb0);
    repeat (1000) @(posedge pclk);
    for (int k = 0; k < 2; k++) begin
      b = (k == 0) ? {ad, 1'b0} : 8'($random(seed));
      ack_on <= (k == 0);
      wr(OFF_DATA, b);
      rd(OFF_STAT);
      chk(r[STAT_DONE_POS], 1'b0);
      wait_done();
      chk(r, (k == 0) ? 32'ha2 : 32'ha3);
      chk(rx_byte, b);
    end
    // Master receive, then leave receive before the final data read
    tx_val <= 8'($random(seed));
    wr(OFF_CTRL, 8'ha0);
    talk <= 1'b1;
    rd(OFF_DATA);
    wait_done();
    chk(r, 32'ha3);
    talk <= 1'b0;
    wr(OFF_CTRL, 8'hb0);
    rd(OFF_DATA);
    chk(r, {24'h0, tx_val});
    repeat (600) @(posedge pclk);
    rd(OFF_STAT);
    chk(r[STAT_DONE_POS], 1'b1);
    wr(OFF_CTRL, 8'h90);
    repeat (1500) @(posedge pclk);
    rd(OFF_STAT);
    chk(r[STAT_BUSY_POS], 1'b0);
    tally_and_finish();
  end
endmodule
